// [fmdc_defs.svh]
// constants for the float multiply, divide and compare unit
`ifndef FMDC_DEFS_SVH
`define FMDC_DEFS_SVH
// ----------------------------------------------------------------
// relation function codes, consecutive
// ----------------------------------------------------------------
`define FMDC_FUNC_EQ 10'h149
`define FMDC_FUNC_NE 10'h14A
`define FMDC_FUNC_LT 10'h14B
`define FMDC_FUNC_LE 10'h14C
`define FMDC_FUNC_GT 10'h14D
`define FMDC_FUNC_GE 10'h14E
// ----------------------------------------------------------------
// register indices on the plain register port
// ----------------------------------------------------------------
`define FMDC_REG_FLAGS 2'h0
`define FMDC_REG_RESULT 2'h1
`define FMDC_REG_COND 2'h2
`define FMDC_REG_STATUS 2'h3
// ----------------------------------------------------------------
// float format and reset values
// ----------------------------------------------------------------
`define FMDC_EXP_BIAS 10'h07F
`define FMDC_EXP_MAX 10'h0FF
`define FMDC_EXP_ONES 8'hFF
`define FMDC_RESULT_RST 32'h00000000
`endif

// [fmdc_pkg.sv]
// types for the float multiply, divide and compare unit
package fmdc_pkg;
   typedef enum logic [1:0] {op_mul, op_div, op_cmp} fmdc_op_e;
   typedef enum logic [1:0] {rung_start_form, and_form, or_form} fmdc_form_e;
   typedef enum logic [1:0] {st_idle, st_fetch, st_exec} fmdc_state_e;
endpackage

// [fmdc_unit.sv]
// float multiply, divide and compare datapath with operand fetch
`include "fmdc_defs.svh"
// Function
// - multiply with a NaN operand raises error, result not written
// - zero times infinity, either order, raises error, no product stored
// - finite product gives zero on underflow, normal, or signed infinity
// - zero or finite over infinity gives zero; finite dividend is underflow
// - divide errors on 0/0, inf/inf of any sign, or any NaN
// - compare operands are IEEE single-precision values, not integers
// - memory operand is two words at address, upper half in next word
// - each compare operand may be an immediate 32-bit constant
// - in load form, condition is true only when the selected relation holds
// - compare sets error when an operand is NaN, and clears it only when neither is NaN or infinite
// - compare also sets error when an operand is infinite
// - compare updates greater, greater-or-equal and equal flags exactly
// - compare updates not-equal, less and less-or-equal flags exactly
// - load form starts condition, and form ands, or form ors
// - all three forms pair with all six relations
// - codes map in order eq, ne, lt, le, gt, ge
// - too large a result sets overflow and writes signed infinity
// - too small a result sets underflow and writes zero
module fmdc_unit (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic start_i,
   input wire fmdc_pkg::fmdc_op_e op_i,
   input wire fmdc_pkg::fmdc_form_e form_i,
   input wire logic [9:0] func_code_i,
   input wire logic src1_imm_i,
   input wire logic [15:0] src1_addr_i,
   input wire logic [31:0] src1_const_i,
   input wire logic src2_imm_i,
   input wire logic [15:0] src2_addr_i,
   input wire logic [31:0] src2_const_i,
   output logic mem_rd_o,
   output logic [15:0] mem_addr_o,
   input wire logic [15:0] mem_data_i,
   output logic [31:0] result_o,
   output logic result_wr_o,
   output logic done_o,
   output logic busy_o,
   output logic cond_o,
   output logic error_flag_o,
   output logic greater_flag_o,
   output logic greater_or_equal_flag_o,
   output logic equal_flag_o,
   output logic not_equal_flag_o,
   output logic less_flag_o,
   output logic less_or_equal_flag_o,
   output logic overflow_flag_o,
   output logic underflow_flag_o,
   output logic negative_flag_o,
   input wire logic [1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o
);
   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_ff, rst_n;
   // async assert, two-flop release so no flop sees a runt deassert
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta_ff <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n <= rst_meta_ff;
      end
   end

   // ----------------------------------------------------------------
   // sequencing and operand fetch state
   // ----------------------------------------------------------------
   fmdc_pkg::fmdc_state_e state_ff, nxt_state;
   fmdc_pkg::fmdc_op_e op_ff, nxt_op;
   fmdc_pkg::fmdc_form_e form_ff, nxt_form;
   logic [9:0] code_ff, nxt_code;
   logic imm1_ff, nxt_imm1, imm2_ff, nxt_imm2;
   logic [15:0] base1_ff, nxt_base1, base2_ff, nxt_base2;
   logic [31:0] opa_ff, nxt_opa, opb_ff, nxt_opb;
   logic [1:0] widx_ff, nxt_widx, ph_ff, nxt_ph;
   logic rd_ff, nxt_rd;
   logic [15:0] addr_ff, nxt_addr;
   logic busy_ff, nxt_busy;
   logic word_imm;

   // word index 0,1 belong to the first operand, 2,3 to the second
   always_comb begin
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_form = form_ff;
      nxt_code = code_ff;
      nxt_imm1 = imm1_ff;
      nxt_imm2 = imm2_ff;
      nxt_base1 = base1_ff;
      nxt_base2 = base2_ff;
      nxt_opa = opa_ff;
      nxt_opb = opb_ff;
      nxt_widx = widx_ff;
      nxt_ph = ph_ff;
      nxt_rd = 1'b0;
      nxt_addr = addr_ff;
      word_imm = widx_ff[1] ? imm2_ff : imm1_ff;
      unique case (state_ff)
         fmdc_pkg::st_idle: begin
            if (start_i) begin
               nxt_state = fmdc_pkg::st_fetch;
               nxt_op = op_i;
               nxt_form = form_i;
               nxt_code = func_code_i;
               nxt_imm1 = src1_imm_i;
               nxt_imm2 = src2_imm_i;
               nxt_base1 = src1_addr_i;
               nxt_base2 = src2_addr_i;
               nxt_opa = src1_const_i;
               nxt_opb = src2_const_i;
               nxt_widx = 2'h0;
               nxt_ph = 2'h0;
            end
         end
         fmdc_pkg::st_fetch: begin
            if (word_imm || ph_ff == 2'h2) begin
               nxt_ph = 2'h0;
               nxt_widx = widx_ff + 2'h1;
               if (widx_ff == 2'h3) begin
                  nxt_state = fmdc_pkg::st_exec;
               end
            end else begin
               nxt_ph = ph_ff + 2'h1;
            end
            if (!word_imm && ph_ff == 2'h0) begin
               nxt_rd = 1'b1;
               // upper half lives in the word after the base
               nxt_addr = (widx_ff[1] ? base2_ff : base1_ff)
                  + {15'h0000, widx_ff[0]};
            end
            // data stand in the cycle after the strobe was out
            if (!word_imm && ph_ff == 2'h2) begin
               unique case (widx_ff)
                  2'h0: nxt_opa[15:0] = mem_data_i;
                  2'h1: nxt_opa[31:16] = mem_data_i;
                  2'h2: nxt_opb[15:0] = mem_data_i;
                  2'h3: nxt_opb[31:16] = mem_data_i;
               endcase
            end
         end
         fmdc_pkg::st_exec: begin
            nxt_state = fmdc_pkg::st_idle;
         end
         default: begin
            nxt_state = fmdc_pkg::st_idle;
         end
      endcase
      nxt_busy = nxt_state != fmdc_pkg::st_idle;
   end

   // registers of the sequencer
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= fmdc_pkg::st_idle;
         op_ff <= fmdc_pkg::op_mul;
         form_ff <= fmdc_pkg::rung_start_form;
         code_ff <= 10'h000;
         imm1_ff <= 1'b0;
         imm2_ff <= 1'b0;
         base1_ff <= 16'h0000;
         base2_ff <= 16'h0000;
         opa_ff <= 32'h00000000;
         opb_ff <= 32'h00000000;
         widx_ff <= 2'h0;
         ph_ff <= 2'h0;
         rd_ff <= 1'b0;
         addr_ff <= 16'h0000;
         busy_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         form_ff <= nxt_form;
         code_ff <= nxt_code;
         imm1_ff <= nxt_imm1;
         imm2_ff <= nxt_imm2;
         base1_ff <= nxt_base1;
         base2_ff <= nxt_base2;
         opa_ff <= nxt_opa;
         opb_ff <= nxt_opb;
         widx_ff <= nxt_widx;
         ph_ff <= nxt_ph;
         rd_ff <= nxt_rd;
         addr_ff <= nxt_addr;
         busy_ff <= nxt_busy;
      end
   end

   // ----------------------------------------------------------------
   // operand classes and arithmetic
   // ----------------------------------------------------------------
   logic sa, sb, sr, az, bz, ainf, binf, anan, bnan;
   logic [23:0] ma, mb;
   logic [47:0] prod, quot;
   logic signed [9:0] emul, ediv;
   logic [31:0] infv;

   // exponent zero counts as zero: subnormals are flushed
   always_comb begin
      sa = opa_ff[31];
      sb = opb_ff[31];
      sr = sa ^ sb;
      az = opa_ff[30:23] == 8'h00;
      bz = opb_ff[30:23] == 8'h00;
      ainf = opa_ff[30:23] == `FMDC_EXP_ONES && opa_ff[22:0] == 23'h0;
      binf = opb_ff[30:23] == `FMDC_EXP_ONES && opb_ff[22:0] == 23'h0;
      anan = opa_ff[30:23] == `FMDC_EXP_ONES && opa_ff[22:0] != 23'h0;
      bnan = opb_ff[30:23] == `FMDC_EXP_ONES && opb_ff[22:0] != 23'h0;
      ma = {1'b1, opa_ff[22:0]};
      mb = {1'b1, opb_ff[22:0]};
      prod = {24'h000000, ma} * {24'h000000, mb};
      quot = {ma, 24'h000000} / {24'h000000, mb};
      emul = $signed({2'h0, opa_ff[30:23]}) + $signed({2'h0, opb_ff[30:23]})
         - $signed(`FMDC_EXP_BIAS) + $signed({9'h000, prod[47]});
      ediv = $signed({2'h0, opa_ff[30:23]}) - $signed({2'h0, opb_ff[30:23]})
         + $signed(`FMDC_EXP_BIAS) - $signed({9'h000, !quot[24]});
      infv = {sr, `FMDC_EXP_ONES, 23'h000000};
   end

   logic ar_err, ar_of, ar_uf;
   logic [31:0] ar_res;
   logic signed [9:0] e_sel;
   logic [22:0] m_sel;

   // special cases first; the finite path truncates toward zero
   always_comb begin
      ar_err = 1'b0;
      ar_of = 1'b0;
      ar_uf = 1'b0;
      ar_res = 32'h00000000;
      e_sel = op_ff == fmdc_pkg::op_div ? ediv : emul;
      m_sel = op_ff == fmdc_pkg::op_div
         ? (quot[24] ? quot[23:1] : quot[22:0])
         : (prod[47] ? prod[46:24] : prod[45:23]);
      if (op_ff == fmdc_pkg::op_mul) begin
         if (anan || bnan) begin
            ar_err = 1'b1;
         end else if ((az && binf) || (bz && ainf)) begin
            ar_err = 1'b1;
         end else if (az || bz) begin
            ar_res = 32'h00000000;
         end else if (ainf || binf) begin
            ar_res = infv;
         end else if (e_sel >= $signed(`FMDC_EXP_MAX)) begin
            ar_of = 1'b1;
            ar_res = infv;
         end else if (e_sel <= $signed(10'h000)) begin
            ar_uf = 1'b1;
         end else begin
            ar_res = {sr, e_sel[7:0], m_sel};
         end
      end else begin
         if (anan || bnan || (az && bz) || (ainf && binf)) begin
            ar_err = 1'b1;
         end else if (az) begin
            ar_res = 32'h00000000;
         end else if (binf) begin
            ar_uf = 1'b1;
         end else if (bz || ainf) begin
            ar_res = infv;
         end else if (e_sel >= $signed(`FMDC_EXP_MAX)) begin
            ar_of = 1'b1;
            ar_res = infv;
         end else if (e_sel <= $signed(10'h000)) begin
            ar_uf = 1'b1;
         end else begin
            ar_res = {sr, e_sel[7:0], m_sel};
         end
      end
   end

   // ----------------------------------------------------------------
   // comparison as signed-magnitude floats
   // ----------------------------------------------------------------
   logic c_eq, c_lt, c_gt, c_nan, c_inf, c_rel, c_code_ok;
   logic mag_lt, mag_gt;

   // +0 and -0 compare equal; NaN makes every relation false but ne
   always_comb begin
      mag_lt = opa_ff[30:0] < opb_ff[30:0];
      mag_gt = opa_ff[30:0] > opb_ff[30:0];
      c_nan = anan || bnan;
      c_inf = ainf || binf;
      c_eq = !c_nan && ((az && bz) || opa_ff == opb_ff);
      if (c_nan || (az && bz)) begin
         c_lt = 1'b0;
      end else if (sa != sb) begin
         c_lt = sa;
      end else begin
         c_lt = sa ? mag_gt : mag_lt;
      end
      c_gt = !c_nan && !c_eq && !c_lt;
      c_code_ok = 1'b1;
      unique case (code_ff)
         `FMDC_FUNC_EQ: c_rel = c_eq;
         `FMDC_FUNC_NE: c_rel = !c_eq;
         `FMDC_FUNC_LT: c_rel = c_lt;
         `FMDC_FUNC_LE: c_rel = c_lt || c_eq;
         `FMDC_FUNC_GT: c_rel = c_gt;
         `FMDC_FUNC_GE: c_rel = c_gt || c_eq;
         default: begin
            c_rel = 1'b0;
            c_code_ok = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // flags, condition, result and register port
   // ----------------------------------------------------------------
   logic [9:0] flags_ff, nxt_flags; // neg,uf,of,le,lt,ne,eq,ge,gt,err
   logic cond_ff, nxt_cond, wr_ff, nxt_wr, done_ff, nxt_done;
   logic [31:0] res_ff, nxt_res, rdata_ff, nxt_rdata;
   logic exec;

   // a compare with a valid code beats a same-cycle software write of the condition
   always_comb begin
      exec = state_ff == fmdc_pkg::st_exec;
      nxt_flags = flags_ff;
      nxt_cond = cond_ff;
      nxt_res = res_ff;
      nxt_wr = 1'b0;
      nxt_done = exec;
      if (reg_wr_i && reg_addr_i == `FMDC_REG_COND) begin
         nxt_cond = reg_wdata_i[0];
      end
      if (exec && op_ff == fmdc_pkg::op_cmp) begin
         if (!c_code_ok) begin
            nxt_flags[0] = 1'b1;
         end else begin
            // only bits 6..0: overflow and underflow belong to arithmetic
            nxt_flags[6:0] = {c_lt || c_eq, c_lt, !c_eq, c_eq,
               c_gt || c_eq, c_gt, c_nan || c_inf};
            // negative flag bit 9 deliberately left alone
            unique case (form_ff)
               fmdc_pkg::rung_start_form: nxt_cond = c_rel;
               fmdc_pkg::and_form: nxt_cond = cond_ff && c_rel;
               fmdc_pkg::or_form: nxt_cond = cond_ff || c_rel;
               default: nxt_cond = cond_ff;
            endcase
         end
      end else if (exec) begin
         if (ar_err) begin
            nxt_flags[0] = 1'b1;
         end else begin
            nxt_flags[0] = 1'b0;
            nxt_flags[3] = ar_res[30:0] == 31'h00000000;
            nxt_flags[7] = ar_of;
            nxt_flags[8] = ar_uf;
            nxt_flags[9] = ar_res[31] && ar_res[30:0] != 31'h0;
            nxt_res = ar_res;
            nxt_wr = 1'b1;
         end
      end
      nxt_rdata = 32'h00000000;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            `FMDC_REG_FLAGS: nxt_rdata = {22'h000000, flags_ff};
            `FMDC_REG_RESULT: nxt_rdata = res_ff;
            `FMDC_REG_COND: nxt_rdata = {31'h00000000, cond_ff};
            `FMDC_REG_STATUS: nxt_rdata = {31'h00000000, busy_ff};
         endcase
      end
   end

   // registers of flags, result and read data
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         flags_ff <= 10'h000;
         cond_ff <= 1'b0;
         res_ff <= `FMDC_RESULT_RST;
         wr_ff <= 1'b0;
         done_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
      end else begin
         flags_ff <= nxt_flags;
         cond_ff <= nxt_cond;
         res_ff <= nxt_res;
         wr_ff <= nxt_wr;
         done_ff <= nxt_done;
         rdata_ff <= nxt_rdata;
      end
   end

   assign mem_rd_o = rd_ff;
   assign mem_addr_o = addr_ff;
   assign result_o = res_ff;
   assign result_wr_o = wr_ff;
   assign done_o = done_ff;
   assign busy_o = busy_ff;
   assign cond_o = cond_ff;
   assign {negative_flag_o, underflow_flag_o, overflow_flag_o,
      less_or_equal_flag_o, less_flag_o, not_equal_flag_o, equal_flag_o,
      greater_or_equal_flag_o, greater_flag_o, error_flag_o} = flags_ff;
   assign reg_rdata_o = rdata_ff;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);
   logic mul_x, div_x, cmp_x;
   assign mul_x = exec && op_ff == fmdc_pkg::op_mul;
   assign div_x = exec && op_ff == fmdc_pkg::op_div;
   assign cmp_x = exec && op_ff == fmdc_pkg::op_cmp && c_code_ok;

   chk_mul_nan_err: assert property (
      mul_x && (anan || bnan) |=> error_flag_o && !result_wr_o)
      else $error("nan multiply not flagged");
   chk_mul_zero_inf: assert property (
      mul_x && ((az && binf) || (bz && ainf)) |=> error_flag_o
      && !result_wr_o && $stable(result_o))
      else $error("zero times infinity stored a product");
   chk_mul_ovf_inf: assert property (
      (mul_x || div_x) && !ar_err && ar_of |=> overflow_flag_o
      && result_wr_o && result_o[30:0] == 31'h7F800000)
      else $error("overflow not written as infinity");
   chk_div_inf_zero: assert property (
      div_x && binf && !ainf && !anan && !az |=> result_wr_o
      && result_o == 32'h00000000 && underflow_flag_o)
      else $error("finite over infinity not zero underflow");
   chk_div_err_skip: assert property (
      div_x && ((az && bz) || (ainf && binf)) |=> error_flag_o
      ##0 !result_wr_o)
      else $error("invalid divide executed");
   chk_div_zero_sign: assert property (
      div_x && bz && !az && !anan |=> result_o[31] == $past(sr)
      && result_o[30:23] == 8'hFF)
      else $error("divide by zero sign wrong");
   chk_cmp_rel_set: assert property (
      cmp_x |=> greater_or_equal_flag_o == (greater_flag_o || equal_flag_o)
      && less_or_equal_flag_o == (less_flag_o || equal_flag_o)
      && not_equal_flag_o == !equal_flag_o)
      else $error("relation flags inconsistent");
   chk_cmp_inf_err: assert property (
      cmp_x && (ainf || binf) |=> error_flag_o)
      else $error("infinite compare operand not flagged");
   chk_cmp_neg_keep: assert property (
      cmp_x |=> $stable(negative_flag_o))
      else $error("compare changed negative flag");
   chk_cond_and_form: assert property (
      cmp_x && form_ff == fmdc_pkg::and_form && !cond_ff
      && !(reg_wr_i && reg_addr_i == `FMDC_REG_COND) |=> !cond_o)
      else $error("and form raised a false condition");
   chk_fetch_pair: assert property (
      mem_rd_o && widx_ff[0] |-> mem_addr_o ==
      (widx_ff[1] ? base2_ff : base1_ff) + 16'h0001)
      else $error("upper half not fetched from next word");
endmodule

// [fmdc_mem_model.sv]
// word memory standing in for the operand store on the fetch port
module fmdc_mem_model (
   input wire logic clk_i,
   input wire logic mem_rd_i,
   input wire logic [15:0] mem_addr_i,
   output logic [15:0] mem_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // storage, loaded by the bench before each instruction
   // ----------------------------------------------------------------
   logic [15:0] words [0:255];
   initial mem_data_o = 16'h0000;
   // answer one cycle after the strobe; otherwise the data lines toggle
   // every cycle so a late or early capture never sees a stale word
   always @(posedge clk_i) begin
      if (mem_rd_i) begin
         mem_data_o <= words[mem_addr_i[7:0]];
      end else begin
         mem_data_o <= ~mem_data_o;
      end
   end
endmodule

// [test_float_mul_div_compare_unit.sv]
// self-checking bench for the float multiply, divide and compare unit
`include "fmdc_defs.svh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
   fail_count++; $display("unexpected %s expected %h seen %h", nm, exp, got); \
   end end
module test_float_mul_div_compare_unit;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, reset_n_i = 1'b0, start_i = 1'b0;
   fmdc_pkg::fmdc_op_e op_i = fmdc_pkg::op_mul;
   fmdc_pkg::fmdc_form_e form_i = fmdc_pkg::rung_start_form;
   logic [9:0] func_code_i = 10'h000;
   logic src1_imm_i = 1'b1, src2_imm_i = 1'b1, mem_rd_o, result_wr_o;
   logic [15:0] src1_addr_i = 16'h0010, src2_addr_i = 16'h0020;
   logic [31:0] src1_const_i = 32'h0, src2_const_i = 32'h0, result_o;
   logic [15:0] mem_addr_o, mem_data_i;
   logic done_o, busy_o, cond_o, error_flag_o, greater_flag_o;
   logic greater_or_equal_flag_o, equal_flag_o, not_equal_flag_o;
   logic less_flag_o, less_or_equal_flag_o, overflow_flag_o;
   logic underflow_flag_o, negative_flag_o, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic [1:0] reg_addr_i = 2'h0;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, last_res = 32'h0, rd;
   logic wr_seen;
   int fail_count = 0, comparisons = 0;
   logic [31:0] pa [0:5] = '{32'h3F800000, 32'hBF800000, 32'h40000000,
      32'h00000000, 32'h7FC00000, 32'h7F800000};
   logic [31:0] pb [0:5] = '{32'h40000000, 32'h3F800000, 32'h3F800000,
      32'h80000000, 32'h3F800000, 32'h3F800000};
   // relation sets in the order eq, ne, lt, le, gt, ge
   logic [5:0] pv [0:5] = '{6'h1C, 6'h1C, 6'h13, 6'h25, 6'h10, 6'h13};
   logic pe [0:5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
   always #20 clk_i = ~clk_i;
   fmdc_unit DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start_i),
      .op_i(op_i), .form_i(form_i), .func_code_i(func_code_i),
      .src1_imm_i(src1_imm_i), .src1_addr_i(src1_addr_i),
      .src1_const_i(src1_const_i), .src2_imm_i(src2_imm_i),
      .src2_addr_i(src2_addr_i), .src2_const_i(src2_const_i),
      .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_data_i(mem_data_i),
      .result_o(result_o), .result_wr_o(result_wr_o), .done_o(done_o),
      .busy_o(busy_o), .cond_o(cond_o), .error_flag_o(error_flag_o),
      .greater_flag_o(greater_flag_o),
      .greater_or_equal_flag_o(greater_or_equal_flag_o),
      .equal_flag_o(equal_flag_o), .not_equal_flag_o(not_equal_flag_o),
      .less_flag_o(less_flag_o), .less_or_equal_flag_o(less_or_equal_flag_o),
      .overflow_flag_o(overflow_flag_o), .underflow_flag_o(underflow_flag_o),
      .negative_flag_o(negative_flag_o), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o));
   fmdc_mem_model FM (.clk_i(clk_i), .mem_rd_i(mem_rd_o),
      .mem_addr_i(mem_addr_o), .mem_data_o(mem_data_i));
   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic close_out();
      if (fail_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // memory operands are laid out low word first, upper half at +1
   task automatic run(input fmdc_pkg::fmdc_op_e op,
      input fmdc_pkg::fmdc_form_e fm, input logic [9:0] code,
      input logic i1, input logic [31:0] a, input logic i2,
      input logic [31:0] b);
      FM.words[8'h10] = a[15:0];
      FM.words[8'h11] = a[31:16];
      FM.words[8'h20] = b[15:0];
      FM.words[8'h21] = b[31:16];
      wr_seen = 1'b0;
      @(posedge clk_i);
      start_i <= 1'b1;
      op_i <= op;
      form_i <= fm;
      func_code_i <= code;
      src1_imm_i <= i1;
      src1_const_i <= i1 ? a : ~a;
      src2_imm_i <= i2;
      src2_const_i <= i2 ? b : ~b;
      @(posedge clk_i);
      start_i <= 1'b0;
      // the longest walk is 14 edges; anything past 30 is a hang
      for (int n = 0; n < 30; n++) begin
         @(posedge clk_i);
         #1;
         if (n == 0) `CHK("busy", 1'b1, busy_o)
         if (result_wr_o === 1'b1) wr_seen = 1'b1;
         if (done_o === 1'b1) begin
            `CHK("idle", 1'b0, busy_o)
            break;
         end
         if (n == 29) `CHK("done", 1'b1, done_o)
      end
   endtask
   task automatic reg_rw(input logic wr, input logic [1:0] a,
      input logic [31:0] d);
      @(posedge clk_i);
      reg_wr_i <= wr;
      reg_rd_i <= ~wr;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      #1;
      rd = reg_rdata_o;
   endtask
   // immediate multiply or divide; an error must leave the result alone
   task automatic arith(input fmdc_pkg::fmdc_op_e op, input logic [31:0] a,
      input logic [31:0] b, input logic err, input logic [31:0] res,
      input logic of, input logic uf);
      run(op, fmdc_pkg::rung_start_form, 10'h000, 1'b1, a, 1'b1, b);
      `CHK("error", err, error_flag_o)
      `CHK("written", ~err, wr_seen)
      `CHK("result", err ? last_res : res, result_o)
      if (!err) begin
         `CHK("overflow", of, overflow_flag_o)
         `CHK("underflow", uf, underflow_flag_o)
         last_res = res;
      end
   endtask
   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      arith(fmdc_pkg::op_mul, 32'h7FC00000, 32'h3F800000, 1, 0, 0, 0);
      arith(fmdc_pkg::op_mul, 32'h40000000, 32'h40400000, 0,
         32'h40C00000, 0, 0);
      arith(fmdc_pkg::op_mul, 32'h00000000, 32'h7F800000, 1, 0, 0, 0);
      arith(fmdc_pkg::op_mul, 32'hFF800000, 32'h00000000, 1, 0, 0, 0);
      arith(fmdc_pkg::op_mul, 32'h7F000000, 32'h7F000000, 0,
         32'h7F800000, 1, 0);
      arith(fmdc_pkg::op_mul, 32'h00800000, 32'h00800000, 0, 0, 0, 1);
      arith(fmdc_pkg::op_mul, 32'h7F800000, 32'hC0000000, 0,
         32'hFF800000, 0, 0);
      arith(fmdc_pkg::op_div, 32'hBF800000, 32'h00000000, 0,
         32'hFF800000, 0, 0);
      arith(fmdc_pkg::op_div, 32'h00000000, 32'hFF800000, 0, 0, 0, 0);
      // underflow left set here: the compares below must not touch it
      arith(fmdc_pkg::op_div, 32'h3F800000, 32'h7F800000, 0, 0, 0, 1);
      arith(fmdc_pkg::op_div, 32'h00000000, 32'h00000000, 1, 0, 0, 0);
      arith(fmdc_pkg::op_div, 32'h7F800000, 32'hFF800000, 1, 0, 0, 0);
      arith(fmdc_pkg::op_div, 32'h3F800000, 32'h7FC00000, 1, 0, 0, 0);
      // every relation against each operand pair, memory and immediate
      for (int p = 0; p < 6; p++) begin
         for (int k = 0; k < 6; k++) begin
            run(fmdc_pkg::op_cmp, fmdc_pkg::rung_start_form,
               `FMDC_FUNC_EQ + 10'(k), k[0], pa[p], ~k[0], pb[p]);
            `CHK("cond", pv[p][5 - k], cond_o)
            `CHK("error", pe[p], error_flag_o)
            `CHK("gt ge eq", {pv[p][1], pv[p][0], pv[p][5]}, {greater_flag_o,
               greater_or_equal_flag_o, equal_flag_o})
            `CHK("ne lt le", pv[p][4:2], {not_equal_flag_o, less_flag_o,
               less_or_equal_flag_o})
            `CHK("underflow", 1'b1, underflow_flag_o)
         end
      end
      // load, and and or forms each follow a condition set through the cond register
      for (int f = 0; f < 3; f++) begin
         for (int k = 0; k < 6; k++) begin
            for (int c = 0; c < 2; c++) begin
               reg_rw(1'b1, `FMDC_REG_COND, {31'h0, c[0]});
               run(fmdc_pkg::op_cmp, fmdc_pkg::fmdc_form_e'(f[1:0]),
                  `FMDC_FUNC_EQ + 10'(k), 1'b1, pa[0], 1'b1, pb[0]);
               `CHK("form", f == 0 ? pv[0][5 - k] : f == 1 ?
                  c[0] & pv[0][5 - k] : c[0] | pv[0][5 - k], cond_o)
            end
         end
      end
      arith(fmdc_pkg::op_mul, 32'hC0000000, 32'h40400000, 0,
         32'hC0C00000, 0, 0);
      `CHK("negative", 1'b1, negative_flag_o)
      run(fmdc_pkg::op_cmp, fmdc_pkg::rung_start_form, `FMDC_FUNC_LT, 1'b0,
         pa[0], 1'b0, pb[0]);
      `CHK("negative", 1'b1, negative_flag_o)
      reg_rw(1'b0, `FMDC_REG_FLAGS, 0);
      `CHK("flags reg", 32'h00000270, rd)
      reg_rw(1'b1, `FMDC_REG_FLAGS, 32'hFFFFFFFF);
      reg_rw(1'b0, `FMDC_REG_FLAGS, 0);
      `CHK("flags reg", 32'h00000270, rd)
      reg_rw(1'b0, `FMDC_REG_RESULT, 0);
      `CHK("result reg", 32'hC0C00000, rd)
      reg_rw(1'b0, `FMDC_REG_COND, 0);
      `CHK("cond reg", 32'h00000001, rd)
      reg_rw(1'b0, `FMDC_REG_STATUS, 0);
      `CHK("status reg", 32'h00000000, rd)
      close_out();
   end
   // 87 instructions of at most 16 cycles each, with margin
   initial begin
      #(40 * 20000);
      fail_count++;
      close_out();
   end
endmodule
